// file: rtl/otsq_pkg.sv
// Constants, register map and types of the output transient sequencer
package otsq_pkg;
	localparam int NFUNC      = 2;
	localparam int VW         = 16;
	localparam int NPT        = 32;
	localparam int IW         = 5;
	localparam int NMEM       = NFUNC + 2;
	localparam int MEM_DWELL  = NFUNC;
	localparam int MEM_REP    = NFUNC + 1;
	localparam int CLK_NS     = 8;
	localparam int TICK_NS    = 1000;
	localparam int TICK_CYC   = TICK_NS / CLK_NS;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MODE   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PCOUNT = 8'h0C;
	localparam logic [7:0] REG_PPER   = 8'h10;
	localparam logic [7:0] REG_PWIDTH = 8'h14;
	localparam logic [7:0] REG_PDUTY  = 8'h18;
	localparam logic [7:0] REG_LCOUNT = 8'h1C;
	localparam logic [7:0] REG_LLEN   = 8'h20;
	localparam logic [7:0] REG_BASE0  = 8'h24;
	localparam logic [7:0] REG_TRIG0  = 8'h2C;
	localparam logic [7:0] REG_LADDR  = 8'h34;
	localparam logic [7:0] REG_LDATA  = 8'h38;
	localparam logic [7:0] REG_OUT0   = 8'h3C;
	localparam logic [7:0] REG_STRIDE = 8'h04;
	localparam int CB_ARM     = 0;
	localparam int CB_ABORT   = 1;
	localparam int CB_RST     = 2;
	localparam int CB_TRIG    = 3;
	localparam int CB_SAVE    = 4;
	localparam int MB_ONCE    = 8;
	localparam int SB_ERR     = 3;
	localparam int SB_DONE    = 4;
	localparam int SB_REFUSED = 5;
	localparam int LA_SEL_LSB = 8;
	localparam int LEN_STRIDE = 8;
	localparam logic [31:0] PCOUNT_RST = 32'h0000_0001;
	localparam logic [31:0] PPER_RST   = 32'h000F_4240;
	localparam logic [31:0] PWIDTH_RST = 32'h0007_A120;
	localparam logic [6:0]  PDUTY_RST  = 7'h32;
	localparam logic [38:0] PCT_FULL   = 39'h00_0000_0064;
	localparam logic [31:0] LCOUNT_RST = 32'h0000_0001;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		M_FIXED = 2'h0,
		M_STEP  = 2'h1,
		M_PULSE = 2'h2,
		M_LIST  = 2'h3
	} otsq_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ARMED = 3'h1,
		ST_PHI   = 3'h2,
		ST_PLO   = 3'h3,
		ST_LOAD  = 3'h4,
		ST_APPLY = 3'h5,
		ST_DWELL = 3'h6
	} otsq_state_t;
endpackage

// file: rtl/otsq_mem.sv
// List point storage with a registered read port
`timescale 1ns/1ps
module otsq_mem #(
	parameter int W = 32,
	parameter int D = 32,
	parameter int A = 5
) (
	input  wire logic         aclk,
	input  wire logic         we,
	input  wire logic [A-1:0] waddr,
	input  wire logic [W-1:0] wdata,
	input  wire logic [A-1:0] raddr,
	output logic      [W-1:0] rdata_ff
);
	logic [W-1:0] mem [D];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end
endmodule // otsq_mem

// file: rtl/otsq_tick.sv
// Microsecond enable pulse divided from the bus clock
`timescale 1ns/1ps
module otsq_tick
	import otsq_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      tick_ff
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} otsq_tick_t;
	otsq_tick_t r, n;

	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (r.cnt == 8'(TICK_CYC - 1)) begin
			n.cnt = 8'h00;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick_ff = r.tick;
endmodule // otsq_tick

// file: rtl/otsq_top.sv
// Output transient sequencer: step, pulse and list forms behind AXI4-Lite
//
// Overview of operation
// - Accepted trigger drives participants to triggered levels
// - Step form copies triggered level into base
// - Pulse low part and end use base
// - List end holds final point values
// - Pulse needs count, period, duty or width
// - Arm command accepts one trigger per event
// - Store 32 points, repeats, sequence count
// - Each point held for its own dwell
// - Points output in supplied order
// - Arm flags error on mismatched list lengths
// - Single-point list repeats for every point
// - Single dwell entry applies to all points
// - Sequence runs programmed count, default one
// - Auto advance on dwell expiry, default
// - Trigger-paced list advances one per trigger
// - Triggers before dwell expiry are discarded
// - Save allowed only after list executed
// - Reset command sets all functions off
// - Idle trigger logic ignores all triggers
// - List completion returns trigger logic idle
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module otsq_top
	import otsq_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [7:0]                araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire logic                      trig_pin,
	output logic [NFUNC-1:0][VW-1:0]       out_level,
	output logic                           save_strobe
);
	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        aw_got;
		logic                        w_got;
		logic [7:0]                  waddr;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		otsq_mode_t [NFUNC-1:0]      mode;
		logic                        step_once;
		logic [31:0]                 pcount;
		logic [31:0]                 period;
		logic [31:0]                 width;
		logic [6:0]                  duty;
		logic                        use_duty;
		logic [31:0]                 lcount;
		logic [NFUNC:0][5:0]         len;
		logic [NFUNC-1:0][VW-1:0]    base;
		logic [NFUNC-1:0][VW-1:0]    trig;
		logic [NFUNC-1:0][VW-1:0]    out;
		logic [2:0]                  lsel;
		logic [IW-1:0]               lidx;
		logic                        mem_we;
		logic [2:0]                  mem_sel;
		logic [IW-1:0]               mem_addr;
		logic [31:0]                 mem_data;
		otsq_state_t                 st;
		logic [IW-1:0]               idx;
		logic [5:0]                  npts;
		logic [31:0]                 pass;
		logic [31:0]                 pulses;
		logic [31:0]                 rep;
		logic [31:0]                 timer;
		logic [31:0]                 hi_us;
		logic                        dwell_done;
		logic                        err;
		logic                        executed;
		logic                        refused;
		logic                        save;
		logic [2:0]                  sync;
		logic                        trig_lvl;
	} otsq_regs_t;

	otsq_regs_t              r, n;
	logic                    tick;
	logic [NMEM-1:0][31:0]   mrd;
	logic [31:0]             rd_val;
	logic                    rd_hit;
	logic [5:0]              np;
	logic                    bad;
	logic                    any_list;
	logic                    any_pulse;
	logic                    trg;
	logic                    wr_go;
	logic                    wr_hit;
	logic [31:0]             wm;
	logic                    arm_cmd;
	logic                    abort_cmd;
	logic                    rst_cmd;
	logic                    save_cmd;
	logic                    last_pt;
	logic [38:0]             prod;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] v;
		v = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				v[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return v;
	endfunction

	otsq_tick u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick_ff (tick)
	);

	// One store per value list, one for dwells, one for repeats
	for (genvar k = 0; k < NMEM; k++) begin : g_mem
		logic [IW-1:0] ra;
		if (k <= MEM_DWELL) begin : g_one
			always_comb begin
				if (r.len[k] == 6'h01) begin
					ra = '0;
				end else begin
					ra = r.idx;
				end
			end
		end else begin : g_seq
			assign ra = r.idx;
		end
		otsq_mem #(.W(32), .D(NPT), .A(IW)) u_mem (
			.aclk     (aclk),
			.we       (r.mem_we && r.mem_sel == 3'(k)),
			.waddr    (r.mem_addr),
			.wdata    (r.mem_data),
			.raddr    (ra),
			.rdata_ff (mrd[k])
		);
	end

	// Form in use and arm-time list length check
	always_comb begin
		any_list = 1'b0;
		any_pulse = 1'b0;
		np = 6'h00;
		bad = 1'b0;
		for (int f = 0; f < NFUNC; f++) begin
			if (r.mode[f] == M_LIST) begin
				any_list = 1'b1;
				if (r.len[f] > np) begin
					np = r.len[f];
				end
			end
			if (r.mode[f] == M_PULSE) begin
				any_pulse = 1'b1;
			end
		end
		for (int f = 0; f < NFUNC; f++) begin
			if (r.mode[f] == M_LIST && r.len[f] != 6'h01 && r.len[f] != np) begin
				bad = 1'b1;
			end
		end
		if (r.len[NFUNC] != 6'h01 && r.len[NFUNC] != np) begin
			bad = 1'b1;
		end
		if (np == 6'h00 || np > 6'(NPT)) begin
			bad = 1'b1;
		end
	end

	// Register read data
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		case (araddr)
			REG_MODE: begin
				rd_val[2*NFUNC-1:0] = r.mode;
				rd_val[MB_ONCE] = r.step_once;
			end
			REG_STATUS: begin
				rd_val[2:0] = r.st;
				rd_val[SB_ERR] = r.err;
				rd_val[SB_DONE] = r.executed;
				rd_val[SB_REFUSED] = r.refused;
			end
			REG_PCOUNT: rd_val = r.pcount;
			REG_PPER:   rd_val = r.period;
			REG_PWIDTH: rd_val = r.width;
			REG_PDUTY:  rd_val[6:0] = r.duty;
			REG_LCOUNT: rd_val = r.lcount;
			REG_LLEN: begin
				for (int k = 0; k <= NFUNC; k++) begin
					rd_val[k*LEN_STRIDE +: 6] = r.len[k];
				end
			end
			REG_LADDR: begin
				rd_val[IW-1:0] = r.lidx;
				rd_val[LA_SEL_LSB +: 3] = r.lsel;
			end
			REG_CTRL, REG_LDATA: rd_val = '0;
			default: begin
				rd_hit = 1'b0;
				for (int f = 0; f < NFUNC; f++) begin
					if (araddr == REG_BASE0 + 8'(f * 4)) begin
						rd_val[VW-1:0] = r.base[f];
						rd_hit = 1'b1;
					end
					if (araddr == REG_TRIG0 + 8'(f * 4)) begin
						rd_val[VW-1:0] = r.trig[f];
						rd_hit = 1'b1;
					end
					if (araddr == REG_OUT0 + 8'(f * 4)) begin
						rd_val[VW-1:0] = r.out[f];
						rd_hit = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb begin
		n = r;
		n.mem_we = 1'b0;
		n.save = 1'b0;
		arm_cmd = 1'b0;
		abort_cmd = 1'b0;
		rst_cmd = 1'b0;
		save_cmd = 1'b0;
		wr_hit = 1'b1;
		wm = wmerge('0, r.wdata, r.wstrb);
		prod = 39'(r.period) * 39'(r.duty);
		last_pt = ({1'b0, r.idx} + 6'h01) >= r.npts;
		// Trigger pin synchroniser with agreement filter
		n.sync = {r.sync[1:0], trig_pin};
		if (r.sync[1] == r.sync[2]) begin
			n.trig_lvl = r.sync[2];
		end
		trg = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.trig_lvl;
		// Write channel
		if (awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.waddr = awaddr;
			n.awready = 1'b0;
		end
		if (wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
			n.wready = 1'b0;
		end
		wr_go = r.aw_got && r.w_got && !r.bvalid;
		if (wr_go) begin
			case (r.waddr)
				REG_CTRL: begin
					arm_cmd = wm[CB_ARM];
					abort_cmd = wm[CB_ABORT];
					rst_cmd = wm[CB_RST];
					trg = trg | wm[CB_TRIG];
					save_cmd = wm[CB_SAVE];
				end
				REG_MODE: begin
					wm = wmerge({23'h0, r.step_once, 4'h0, r.mode}, r.wdata, r.wstrb);
					n.mode = wm[2*NFUNC-1:0];
					n.step_once = wm[MB_ONCE];
				end
				REG_PCOUNT: n.pcount = wmerge(r.pcount, r.wdata, r.wstrb);
				REG_PPER:   n.period = wmerge(r.period, r.wdata, r.wstrb);
				REG_PWIDTH: begin
					n.width = wmerge(r.width, r.wdata, r.wstrb);
					n.use_duty = 1'b0;
				end
				REG_PDUTY: begin
					wm = wmerge({25'h0, r.duty}, r.wdata, r.wstrb);
					n.duty = wm[6:0];
					n.use_duty = 1'b1;
				end
				REG_LCOUNT: n.lcount = wmerge(r.lcount, r.wdata, r.wstrb);
				REG_LLEN: begin
					for (int k = 0; k <= NFUNC; k++) begin
						if (r.wstrb[k]) begin
							n.len[k] = r.wdata[k*LEN_STRIDE +: 6];
						end
					end
					n.executed = 1'b0;
				end
				REG_LADDR: begin
					n.lidx = r.wdata[IW-1:0];
					n.lsel = r.wdata[LA_SEL_LSB +: 3];
				end
				REG_LDATA: begin
					n.mem_we = 1'b1;
					n.mem_sel = r.lsel;
					n.mem_addr = r.lidx;
					n.mem_data = r.wdata;
					n.lidx = r.lidx + 5'h01;
					n.executed = 1'b0;
				end
				default: begin
					wr_hit = 1'b0;
					for (int f = 0; f < NFUNC; f++) begin
						if (r.waddr == REG_BASE0 + 8'(f * 4)) begin
							wm = wmerge(32'(r.base[f]), r.wdata, r.wstrb);
							n.base[f] = wm[VW-1:0];
							wr_hit = 1'b1;
						end
						if (r.waddr == REG_TRIG0 + 8'(f * 4)) begin
							wm = wmerge(32'(r.trig[f]), r.wdata, r.wstrb);
							n.trig[f] = wm[VW-1:0];
							wr_hit = 1'b1;
						end
					end
				end
			endcase
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (r.bvalid && bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end
		// Read channel
		if (arvalid && r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rd_val;
			n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (r.rvalid && rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		// Save only once the list has run
		if (save_cmd) begin
			n.save = r.executed;
			n.refused = !r.executed;
		end
		// Sequencer
		unique case (r.st)
			ST_IDLE: begin
				if (arm_cmd) begin
					n.npts = np;
					n.idx = '0;
					n.pass = '0;
					n.pulses = '0;
					n.hi_us = r.use_duty ? 32'(prod / PCT_FULL) : r.width;
					n.err = any_list && bad;
					n.st = (any_list && bad) ? ST_IDLE : ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (trg) begin
					if (any_list) begin
						n.idx = '0;
						n.st = ST_LOAD;
					end else if (any_pulse) begin
						n.timer = r.hi_us;
						n.st = ST_PHI;
					end else begin
						n.st = ST_IDLE;
					end
					for (int f = 0; f < NFUNC; f++) begin
						if (r.mode[f] == M_STEP || r.mode[f] == M_PULSE) begin
							n.out[f] = r.trig[f];
						end
						if (r.mode[f] == M_STEP) begin
							n.base[f] = r.trig[f];
						end
					end
				end
			end
			ST_PHI: begin
				if (r.timer == '0) begin
					n.timer = (r.period > r.hi_us) ? r.period - r.hi_us : '0;
					n.st = ST_PLO;
					for (int f = 0; f < NFUNC; f++) begin
						n.out[f] = r.base[f];
					end
				end else if (tick) begin
					n.timer = r.timer - 32'h1;
				end
			end
			ST_PLO: begin
				if (r.timer == '0) begin
					n.pulses = r.pulses + 32'h1;
					if (r.pulses + 32'h1 >= r.pcount) begin
						n.st = ST_IDLE;
					end else begin
						n.timer = r.hi_us;
						n.st = ST_PHI;
						for (int f = 0; f < NFUNC; f++) begin
							if (r.mode[f] == M_PULSE) begin
								n.out[f] = r.trig[f];
							end
						end
					end
				end else if (tick) begin
					n.timer = r.timer - 32'h1;
				end
			end
			ST_LOAD: begin
				n.st = ST_APPLY;
			end
			ST_APPLY: begin
				for (int f = 0; f < NFUNC; f++) begin
					if (r.mode[f] == M_LIST) begin
						n.out[f] = mrd[f][VW-1:0];
					end
				end
				n.timer = mrd[MEM_DWELL];
				n.rep = (mrd[MEM_REP] == '0) ? 32'h1 : mrd[MEM_REP];
				n.dwell_done = 1'b0;
				n.st = ST_DWELL;
			end
			ST_DWELL: begin
				if (!r.dwell_done) begin
					if (r.timer == '0) begin
						if (r.rep > 32'h1) begin
							n.rep = r.rep - 32'h1;
							n.timer = mrd[MEM_DWELL];
						end else begin
							n.dwell_done = 1'b1;
						end
					end else if (tick) begin
						n.timer = r.timer - 32'h1;
					end
				end else if (last_pt && r.pass + 32'h1 >= r.lcount) begin
					n.executed = 1'b1;
					n.st = ST_IDLE;
				end else if (!r.step_once || trg) begin
					n.idx = last_pt ? '0 : r.idx + 5'h01;
					n.pass = last_pt ? r.pass + 32'h1 : r.pass;
					n.st = ST_LOAD;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		// Base level outside running transients
		for (int f = 0; f < NFUNC; f++) begin
			if (r.mode[f] == M_FIXED ||
				((n.st == ST_IDLE || n.st == ST_ARMED) && r.mode[f] != M_LIST)) begin
				n.out[f] = n.base[f];
			end
		end
		if (abort_cmd) begin
			n.st = ST_IDLE;
		end
		if (rst_cmd) begin
			n.st = ST_IDLE;
			n.mode = '0;
			n.step_once = 1'b0;
			n.lcount = LCOUNT_RST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.pcount <= PCOUNT_RST;
			r.period <= PPER_RST;
			r.width <= PWIDTH_RST;
			r.duty <= PDUTY_RST;
			r.lcount <= LCOUNT_RST;
		end else begin
			r <= n;
		end
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign out_level = r.out;
	assign save_strobe = r.save;
endmodule // otsq_top

// file: test/otsq_top_monitor.sv
// Port checker for the output transient sequencer
`timescale 1ns/1ps
module otsq_chk
	import otsq_pkg::*;
(
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                awvalid,
	input wire logic                awready,
	input wire logic                wvalid,
	input wire logic                wready,
	input wire logic [1:0]          bresp,
	input wire logic                bvalid,
	input wire logic                bready,
	input wire logic                arvalid,
	input wire logic                arready,
	input wire logic [31:0]         rdata,
	input wire logic [1:0]          rresp,
	input wire logic                rvalid,
	input wire logic                rready,
	input wire logic [NFUNC-1:0][VW-1:0] out_level,
	input wire logic                save_strobe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_aw_refuse: assert property (awvalid && awready |=> !awready)
		else $error("write address taken twice");
	a_w_refuse: assert property (wvalid && wready |=> !wready)
		else $error("write data taken twice");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not released");
	a_r_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
		else $error("error read carries data");
	a_save_pulse: assert property (save_strobe |=> !save_strobe)
		else $error("save strobe too long");
	c_save: cover property (save_strobe);
	c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
	c_out: cover property (out_level != $past(out_level));
endmodule // otsq_chk

// file: test/tb.sv
// Directed testbench of the output transient sequencer
`timescale 1ns/1ps
module tb;
	import otsq_pkg::*;
	logic aclk = 0, aresetn = 0, trig_pin = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, save_strobe;
	logic [1:0] bresp, rresp, lresp;
	logic [NFUNC-1:0][VW-1:0] out_level;
	int error_cnt = 0, checks = 0;
	logic [31:0] v;
	always #4 aclk = ~aclk;
	otsq_top u_otsq_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.trig_pin(trig_pin), .out_level(out_level), .save_strobe(save_strobe));
	task automatic results();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	task automatic tmo();
		error_cnt++;
		$display("[ERR] wait expected done seen timeout");
		results();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, dd;
		int n;
		ad = 0; dd = 0; n = 0;
		awaddr <= a; wdata <= d; wstrb <= 4'hF;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge aclk); n++;
			if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
			if (!dd && wready === 1'b1) begin dd = 1; wvalid <= 0; end
		end while (!(ad && dd && bvalid === 1'b1) && n < 100);
		lresp = bresp;
		bready <= 0;
		@(posedge aclk);
		if (n >= 100) tmo();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ad;
		int n;
		ad = 0; n = 0;
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge aclk); n++;
			if (!ad && arready === 1'b1) begin ad = 1; arvalid <= 0; end
			else if (ad && rvalid === 1'b1) break;
		end while (n < 100);
		d = rdata; lresp = rresp;
		rready <= 0;
		@(posedge aclk);
		if (n >= 100) tmo();
	endtask
	task automatic pt();
		trig_pin <= 1;
		repeat (6) @(posedge aclk);
		trig_pin <= 0;
		repeat (6) @(posedge aclk);
	endtask
	task automatic wi();
		int n;
		n = 0;
		do begin rd(REG_STATUS, v); n++; end while (v[2:0] !== 3'h0 && n < 900);
		if (n >= 900) tmo();
	endtask
	task automatic t_reset();
		rd(REG_PCOUNT, v); chk("pcount", v, PCOUNT_RST);
		rd(REG_PPER, v); chk("period", v, PPER_RST);
		rd(REG_PWIDTH, v); chk("width", v, PWIDTH_RST);
		rd(REG_PDUTY, v); chk("duty", v, {25'h0, PDUTY_RST});
		rd(REG_LCOUNT, v); chk("lcount", v, LCOUNT_RST);
		rd(REG_MODE, v); chk("mode", v, 32'h0);
		rd(REG_STATUS, v); chk("status", v, 32'h0);
		rd(8'hFC, v); chk("rd resp", {30'h0, lresp}, {30'h0, RESP_SLVERR});
		wr(8'hF0, 32'h1); chk("wr resp", {30'h0, lresp}, {30'h0, RESP_SLVERR});
	endtask
	task automatic t_step();
		wr(REG_BASE0, 32'h10); wr(REG_BASE0 + 8'h04, 32'h20);
		wr(REG_TRIG0, 32'h55); wr(REG_TRIG0 + 8'h04, 32'h99);
		wr(REG_MODE, 32'h1);
		pt(); chk("idle trig", out_level[0], 32'h10);
		wr(REG_CTRL, 32'h1); pt();
		chk("step out0", out_level[0], 32'h55);
		chk("step out1", out_level[1], 32'h20);
		rd(REG_BASE0, v); chk("step base", v, 32'h55);
		wr(REG_TRIG0, 32'h66); pt();
		chk("one trigger", out_level[0], 32'h55);
	endtask
	task automatic t_pulse();
		int np, hl, h;
		np = 0; hl = 0; h = 0;
		wr(REG_TRIG0, 32'hAA); wr(REG_MODE, 32'h2);
		wr(REG_PCOUNT, 32'h2); wr(REG_PPER, 32'h4);
		wr(REG_PWIDTH, 32'h3); wr(REG_PDUTY, 32'h32);
		wr(REG_CTRL, 32'h1); wr(REG_CTRL, 32'h8);
		repeat (1500) begin
			@(posedge aclk);
			if (out_level[0] === 16'hAA) begin
				if (h == 0) begin np++; hl = 0; end
				h = 1; hl++;
			end else h = 0;
		end
		chk("pulses", np, 2);
		chk("high len ok", hl > 125 && hl <= 252, 1);
		chk("pulse end", out_level[0], 32'h55);
		wi();
		wr(REG_PCOUNT, 32'h1); wr(REG_PWIDTH, 32'h4);
		wr(REG_CTRL, 32'h1); wr(REG_CTRL, 32'h8);
		hl = 0;
		repeat (600) begin
			@(posedge aclk);
			if (out_level[0] === 16'hAA) hl++;
		end
		chk("width wins", hl > 300 && hl <= 502, 1);
		wi();
	endtask
	task automatic t_list();
		logic [15:0] q[$];
		logic [15:0] p;
		q = {};
		wr(REG_LADDR, 32'h0); wr(REG_LDATA, 32'h1); wr(REG_LDATA, 32'h2);
		wr(REG_LDATA, 32'h3); wr(REG_LADDR, 32'h100); wr(REG_LDATA, 32'h77);
		wr(REG_LADDR, 32'h200); wr(REG_LDATA, 32'h2);
		wr(REG_LADDR, 32'h300); wr(REG_LDATA, 32'h1);
		wr(REG_LDATA, 32'h1); wr(REG_LDATA, 32'h1);
		wr(REG_LLEN, 32'h10103); wr(REG_LCOUNT, 32'h2);
		wr(REG_CTRL, 32'h10); rd(REG_STATUS, v);
		chk("refused", v[SB_REFUSED], 1);
		wr(REG_MODE, 32'hF); wr(REG_CTRL, 32'h1); wr(REG_CTRL, 32'h8);
		p = out_level[0];
		repeat (2000) begin
			@(posedge aclk);
			if (out_level[0] !== p) q.push_back(out_level[0]);
			p = out_level[0];
		end
		chk("points", q.size(), 6);
		foreach (q[i]) chk("order", q[i], i % 3 + 1);
		chk("list out1", out_level[1], 32'h77);
		chk("list end", out_level[0], 32'h3);
		rd(REG_STATUS, v); chk("list idle", v[4:0], 5'h10);
		fork wr(REG_CTRL, 32'h10); join_none
		repeat (20) begin
			@(posedge aclk);
			if (save_strobe === 1'b1) p = 16'h5A;
		end
		chk("saved", p, 32'h5A);
	endtask
	task automatic t_paced();
		wr(REG_MODE, 32'h10F); wr(REG_LCOUNT, 32'h1);
		wr(REG_LADDR, 32'h200); wr(REG_LDATA, 32'h4);
		wr(REG_CTRL, 32'h1); pt();
		chk("paced p0", out_level[0], 32'h1);
		pt(); chk("early trig", out_level[0], 32'h1);
		repeat (600) @(posedge aclk);
		pt(); chk("paced p1", out_level[0], 32'h2);
		wr(REG_CTRL, 32'h2); wi();
	endtask
	task automatic t_len();
		wr(REG_LLEN, 32'h10203); wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, v); chk("len err", v[3:0], 4'h8);
		wr(REG_CTRL, 32'h4); rd(REG_MODE, v); chk("rst mode", v, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset(); t_step(); t_pulse(); t_list(); t_paced(); t_len();
		results();
	end
endmodule // tb
bind otsq_top otsq_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.out_level(out_level), .save_strobe(save_strobe));
